/* supply_fault_cfg.svh */
// Timing counts and field positions for the supply fault and bus abort logic.
// Assumes nothing of its surroundings; included by the package and the design file.
`ifndef SUPPLY_FAULT_CFG_SVH
`define SUPPLY_FAULT_CFG_SVH

`define SUPPLY_COUNT        4
`define SUP_BUS             0
`define SUP_BUFFER          1
`define SUP_DIGITAL         2
`define SUP_ANALOG          3
`define STATUS_ONE_WIDTH    8
`define STATUS_ONE_CAP_BIT  3
`define CAP_SETTLE_NS       500
`define CLK_PERIOD_NS       25
`define CAP_SETTLE_CYCLES   ((`CAP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* supply_fault_pkg.sv */
// Types for the supply fault and bus abort logic.
// Assumes the constants header sits in the same folder.
`include "supply_fault_cfg.svh"

package supply_fault_pkg;

	typedef enum logic [1:0] {
		MODE_CRM,
		MODE_PDCM,
		MODE_PSI5
	} bus_mode_e;

	typedef enum logic [1:0] {
		CAP_IDLE,
		CAP_SETTLE,
		CAP_SAMPLE
	} cap_state_e;

	typedef logic [`STATUS_ONE_WIDTH-1:0] status_one_t;

endpackage

/* supply_fault_bus_abort.sv */
// Supply supervision: internal reset, transfer abort, diagnostic flush and buffer capacitor flag.
// Assumes comparator levels arrive asynchronously and the protocol engine runs on clk.
// How it works
// RL1: Internal reset stays asserted after power-up until all monitored supplies are good.
// RL2: Internal reset asserts whenever any monitored supply drops below its threshold.
// RL3: Bus, buffer, digital and analog supplies are watched; any drop is a fault.
// RL4: Fault during command-response command reception discards it and suppresses its response.
// RL5: Fault during command-response response stops it at once, never resent.
// RL6: After recovery in command-response mode, command decoding restarts.
// RL7: Fault during periodic command reception discards it and skips that period's response.
// RL8: Fault during periodic response stops it, no retransmission.
// RL9: Periodic-mode fault flushes partial diagnostic command; assembly restarts with next frames.
// RL10: Fault during diagnostic response stops it, not resent.
// RL11: After recovery in periodic mode, periodic responses resume for later commands.
// RL12: In PSI5, a fault ends the current response frame at once.
// RL13: In PSI5, responses resume once supply is good again.
// RL14: Buffer supply low from missing capacitor sets the capacitor fault bit in status one.
// RL15: The capacitor check is scheduled in step with protocol transmissions.
// RL16: Each comparator is synchronised, then OR-ed into one fault level driving abort logic.
`timescale 1ns/100ps
`include "supply_fault_cfg.svh"

module supply_fault_bus_abort (
	input  wire logic                                  clk,
	input  wire logic                                  reset_n,
	input  wire logic [`SUPPLY_COUNT-1:0]              supply_good,
	input  wire supply_fault_pkg::bus_mode_e           bus_mode,
	input  wire logic                                  cmd_receiving,
	input  wire logic                                  cmd_done,
	input  wire logic                                  resp_sending,
	input  wire logic                                  diag_resp_sending,
	input  wire logic                                  diag_frame_partial,
	input  wire logic                                  tx_start,
	input  wire logic                                  status_one_clear,
	output logic                                       internal_reset_n,
	output logic                                       supply_fault,
	output logic                                       cmd_discard,
	output logic                                       resp_abort,
	output logic                                       diag_resp_abort,
	output logic                                       diag_flush,
	output logic                                       decode_enable,
	output logic                                       resp_enable,
	output supply_fault_pkg::status_one_t              device_status_one
);

	// ************************************************************
	// Supply comparator synchronisers.
	// ************************************************************
	logic [`SUPPLY_COUNT-1:0] good_meta_q;
	logic [`SUPPLY_COUNT-1:0] good_sync_q;
	logic                     fault_q;
	logic                     fault_d;
	logic                     rst_n_q;
	logic                     rst_n_d;

	// Only the second stage is read, because the first may still be settling from metastability.

	always_comb
	begin
		fault_d = |(~good_sync_q); // [RL3] [RL16]
		rst_n_d = ~fault_d;        // [RL1] [RL2]
	end

	// Reset value of the synchroniser means every supply is taken as bad until proven good.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			good_meta_q <= 4'h0;
			good_sync_q <= 4'h0;
			fault_q     <= 1'h1;
			rst_n_q     <= 1'h0;
		end
		else
		begin
			good_meta_q <= supply_good;
			good_sync_q <= good_meta_q; // [RL16]
			fault_q     <= fault_d;
			rst_n_q     <= rst_n_d;
		end
	end

	assign supply_fault     = fault_q;
	assign internal_reset_n = rst_n_q;

	// ************************************************************
	// Transfer abort and diagnostic flush.
	// ************************************************************
	// The abort flags are levels, so the protocol engine must drop the frame rather than retry it.
	logic discard_q;
	logic discard_d;
	logic abort_q;
	logic abort_d;
	logic diag_abort_q;
	logic diag_abort_d;
	logic flush_q;
	logic flush_d;
	logic decode_q;
	logic decode_d;
	logic resp_en_q;
	logic resp_en_d;
	logic skip_q;
	logic skip_d;

	always_comb
	begin
		discard_d    = fault_d & cmd_receiving & (bus_mode != supply_fault_pkg::MODE_PSI5); // [RL4] [RL7]
		abort_d      = fault_d & resp_sending;      // [RL5] [RL8] [RL12]
		diag_abort_d = fault_d & diag_resp_sending; // [RL10]
		flush_d      = fault_d & diag_frame_partial & (bus_mode == supply_fault_pkg::MODE_PDCM); // [RL9]
		decode_d     = ~fault_d;                    // [RL6]
		// A command torn by the fault outside PSI5 cancels the response of its period; the next whole command re-arms it.
		skip_d = skip_q;
		if (discard_d)
		begin
			skip_d = 1'h1; // [RL4] [RL7]
		end
		else if (cmd_done && !fault_d)
		begin
			skip_d = 1'h0; // [RL11]
		end
		resp_en_d = ~fault_d & ~skip_d; // [RL11] [RL13]
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			discard_q    <= 1'h0;
			abort_q      <= 1'h0;
			diag_abort_q <= 1'h0;
			flush_q      <= 1'h0;
			decode_q     <= 1'h0;
			resp_en_q    <= 1'h0;
			skip_q       <= 1'h0;
		end
		else
		begin
			discard_q    <= discard_d;
			abort_q      <= abort_d;
			diag_abort_q <= diag_abort_d;
			flush_q      <= flush_d;
			decode_q     <= decode_d;
			resp_en_q    <= resp_en_d;
			skip_q       <= skip_d;
		end
	end

	assign cmd_discard     = discard_q;
	assign resp_abort      = abort_q;
	assign diag_resp_abort = diag_abort_q;
	assign diag_flush      = flush_q;
	assign decode_enable   = decode_q;
	assign resp_enable     = resp_en_q;

	// ************************************************************
	// Buffer capacitor check.
	// ************************************************************
	localparam int unsigned SETTLE = `CAP_SETTLE_CYCLES;
	// Eight counter bits leave room to lengthen the settle time without touching the logic.
	supply_fault_pkg::cap_state_e  cap_q;
	supply_fault_pkg::cap_state_e  cap_d;
	logic [7:0]                    cnt_q;
	logic [7:0]                    cnt_d;
	supply_fault_pkg::status_one_t stat_q;
	supply_fault_pkg::status_one_t stat_d;

	// The check only looks under transmit load, where a missing capacitor actually sags the rail.
	always_comb
	begin
		cap_d  = cap_q;
		cnt_d  = cnt_q;
		stat_d = stat_q;
		// The clear comes first, so a capacitor fault seen in the same cycle wins.
		if (status_one_clear)
		begin
			stat_d[`STATUS_ONE_CAP_BIT] = 1'h0;
		end
		unique case (cap_q)
			supply_fault_pkg::CAP_IDLE:
			begin
				if (tx_start) // [RL15]
				begin
					cap_d = supply_fault_pkg::CAP_SETTLE;
					cnt_d = 8'h00;
				end
			end
			supply_fault_pkg::CAP_SETTLE:
			begin
				cnt_d = cnt_q + 8'h01;
				if (cnt_q == 8'(SETTLE - 1))
				begin
					cap_d = supply_fault_pkg::CAP_SAMPLE;
				end
			end
			supply_fault_pkg::CAP_SAMPLE:
			begin
				if (!good_sync_q[`SUP_BUFFER])
				begin
					stat_d[`STATUS_ONE_CAP_BIT] = 1'h1; // [RL14]
				end
				cap_d = supply_fault_pkg::CAP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cap_q  <= supply_fault_pkg::CAP_IDLE;
			cnt_q  <= 8'h00;
			stat_q <= 8'h00;
		end
		else
		begin
			cap_q  <= cap_d;
			cnt_q  <= cnt_d;
			stat_q <= stat_d;
		end
	end

	assign device_status_one = stat_q;

endmodule // supply_fault_bus_abort

/* supply_fault_props.sv */
// Assertion checker for the supply fault and bus abort block.
// Assumes only the block's ports; the bind sits after endmodule.
`timescale 1ns/100ps
`include "supply_fault_cfg.svh"
module supply_fault_props (
	input logic                          clk, reset_n, cmd_receiving, resp_sending, diag_resp_sending,
	input logic                          diag_frame_partial, status_one_clear, internal_reset_n, supply_fault,
	input logic                          cmd_discard, resp_abort, diag_resp_abort, diag_flush, decode_enable,
	input logic                          resp_enable,
	input logic [`SUPPLY_COUNT-1:0]      supply_good,
	input supply_fault_pkg::bus_mode_e   bus_mode,
	input supply_fault_pkg::status_one_t device_status_one
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Five samples leave room for the two sync flops and the fault register.
	reset_tie_a: assert property (supply_fault != internal_reset_n) else $error("reset out of step");
	reset_hold_a: assert property (!(&supply_good) |-> ##3 !internal_reset_n) else $error("reset not held");
	fault_detect_a: assert property (!(&supply_good) [*5] |-> supply_fault) else $error("fault missed");
	fault_clear_a: assert property ((&supply_good) [*5] |-> !supply_fault) else $error("fault stuck");
	cmd_discard_a: assert property (cmd_receiving && bus_mode != supply_fault_pkg::MODE_PSI5
		##1 supply_fault |-> cmd_discard) else $error("no discard");
	resp_abort_a: assert property (resp_sending ##1 supply_fault |-> resp_abort) else $error("no abort");
	diag_abort_a: assert property (diag_resp_sending ##1 supply_fault |-> diag_resp_abort)
		else $error("no diag abort");
	diag_flush_a: assert property (diag_frame_partial && bus_mode == supply_fault_pkg::MODE_PDCM
		##1 supply_fault |-> diag_flush) else $error("no flush");
	psi5_no_discard_a: assert property (bus_mode == supply_fault_pkg::MODE_PSI5 |=> !cmd_discard)
		else $error("discard in psi5");
	flush_pdcm_only_a: assert property (bus_mode != supply_fault_pkg::MODE_PDCM |=> !diag_flush)
		else $error("flush outside pdcm");
	abort_release_a: assert property (!supply_fault |-> !resp_abort) else $error("abort stuck");
	decode_off_a: assert property (supply_fault [*2] |-> !decode_enable) else $error("decode on in fault");
	resp_off_a: assert property (supply_fault [*2] |-> !resp_enable) else $error("resp on in fault");
	cap_sticky_a: assert property (device_status_one[3] && !status_one_clear |=> device_status_one[3])
		else $error("cap flag lost");
	cover property (resp_abort);
	cover property (diag_flush);
	cover property ($rose(device_status_one[3]));
	cover property (cmd_discard && bus_mode == supply_fault_pkg::MODE_PDCM);
endmodule // supply_fault_props
bind supply_fault_bus_abort supply_fault_props u_props (.clk, .reset_n, .cmd_receiving, .resp_sending,
	.diag_resp_sending, .diag_frame_partial, .status_one_clear, .internal_reset_n, .supply_fault, .cmd_discard,
	.resp_abort, .diag_resp_abort, .diag_flush, .decode_enable, .resp_enable, .supply_good, .bus_mode,
	.device_status_one);

/* bus_master_model.sv */
// Far-side model: turns a request vector into protocol activity levels.
// Assumes the bench changes the request just after a rising edge.
`timescale 1ns/100ps
module bus_master_model (
	input logic        clk,
	input logic [5:0]  req,
	output logic       cmd_receiving, resp_sending, diag_resp_sending, diag_frame_partial, tx_start, cmd_done
);
	// The master never retries an aborted frame; the bench simply drops the request.
	logic [5:0] act_q = 6'h00;
	always @(posedge clk)
		act_q <= req;
	assign {cmd_done, tx_start, diag_frame_partial, diag_resp_sending, resp_sending, cmd_receiving} = act_q;
endmodule // bus_master_model

/* supply_fault_bus_abort_bench.sv */
// Self-checking bench for the supply fault and bus abort block.
// Assumes the checker is bound by its own file and the master model drives the protocol levels.
`timescale 1ns/100ps
`include "supply_fault_cfg.svh"
module supply_fault_bus_abort_bench;
	logic                          clk = 1'b0, reset_n = 1'b0, status_one_clear = 1'b0;
	logic [`SUPPLY_COUNT-1:0]      supply_good = 4'hF;
	logic [5:0]                    req = 6'h00;
	supply_fault_pkg::bus_mode_e   bus_mode = supply_fault_pkg::MODE_CRM;
	logic                          cmd_receiving, cmd_done, resp_sending, diag_resp_sending, diag_frame_partial;
	logic                          tx_start, internal_reset_n, supply_fault, cmd_discard, resp_abort;
	logic                          diag_resp_abort, diag_flush, decode_enable, resp_enable;
	supply_fault_pkg::status_one_t device_status_one;
	int                            errors = 0, checks_done = 0;
	always #12.5 clk = !clk;
	bus_master_model u_master (.clk, .req, .cmd_receiving, .resp_sending, .diag_resp_sending, .diag_frame_partial,
		.tx_start, .cmd_done);
	supply_fault_bus_abort u_dut (.clk, .reset_n, .supply_good, .bus_mode, .cmd_receiving, .cmd_done, .resp_sending,
		.diag_resp_sending, .diag_frame_partial, .tx_start, .status_one_clear, .internal_reset_n, .supply_fault,
		.cmd_discard, .resp_abort, .diag_resp_abort, .diag_flush, .decode_enable, .resp_enable, .device_status_one);
	task step(int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task chk(string what, logic [7:0] exp, logic [7:0] got);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task t_drop(supply_fault_pkg::bus_mode_e m, logic [5:0] r, int i);
		bus_mode = m;
		req = r;
		step(2);
		supply_good[i] = 1'b0;
		step(5);
		chk("internal_reset_n", 8'h00, internal_reset_n);
		req = 6'h00;
		supply_good[i] = 1'b1;
	endtask
	task t_crm;
		for (int i = 0; i < `SUPPLY_COUNT; i++)
		begin
			t_drop(supply_fault_pkg::MODE_CRM, 6'h03, i);
			chk("cmd_discard", 8'h01, cmd_discard);
			chk("resp_abort", 8'h01, resp_abort);
			chk("decode_enable", 8'h00, decode_enable);
			step(6);
			chk("decode_enable", 8'h01, decode_enable);
			chk("resp_enable", 8'h00, resp_enable);
		end
		$display("crm done");
	endtask
	task t_pdcm;
		t_drop(supply_fault_pkg::MODE_PDCM, 6'h0F, 2);
		chk("diag_flush", 8'h01, diag_flush);
		chk("diag_resp_abort", 8'h01, diag_resp_abort);
		chk("resp_abort", 8'h01, resp_abort);
		chk("cmd_discard", 8'h01, cmd_discard);
		step(6);
		chk("diag_flush", 8'h00, diag_flush);
		chk("resp_enable", 8'h00, resp_enable);
		req = 6'h20;
		step(1);
		req = 6'h00;
		step(3);
		chk("resp_enable", 8'h01, resp_enable);
		$display("pdcm done");
	endtask
	task t_psi5;
		t_drop(supply_fault_pkg::MODE_PSI5, 6'h03, 0);
		chk("cmd_discard", 8'h00, cmd_discard);
		chk("resp_abort", 8'h01, resp_abort);
		step(6);
		chk("resp_enable", 8'h01, resp_enable);
		$display("psi5 done");
	endtask
	task t_cap;
		bus_mode = supply_fault_pkg::MODE_CRM;
		supply_good[1] = 1'b0;
		step(5);
		req = 6'h10;
		step(1);
		req = 6'h00;
		step(10);
		chk("cap flag early", 8'h00, device_status_one);
		step(15);
		chk("cap flag", 8'h08, device_status_one);
		supply_good[1] = 1'b1;
		status_one_clear = 1'b1;
		step(1);
		status_one_clear = 1'b0;
		step(2);
		chk("cap flag cleared", 8'h00, device_status_one);
		$display("cap done");
	endtask
	initial
	begin
		step(8);
		reset_n = 1'b1;
		step(6);
		chk("internal_reset_n", 8'h01, internal_reset_n);
		t_crm;
		t_pdcm;
		t_psi5;
		t_cap;
		test_done;
	end
	// The tests need about 130 cycles; over twenty times that means a hang.
	initial
	begin
		#(3000 * 25);
		errors++;
		test_done;
	end
endmodule // supply_fault_bus_abort_bench
